// file: design/gfs_top.sv
/*
 * Six-pin function selector: each pin either fires a command strobe on an
 * edge or drives a selected internal signal (clock, exception flag,
 * exception channel, receive buffer level).
 * Assumes exception flags and receive buffer status come from logic on
 * core_clk; pin inputs are asynchronous. Registers are reached over a
 * plain strobe port with read data one cycle after the read strobe.
 */
// Our own choices: the strobed register port and the register offsets.
//
// Overview of operation
// - Code 0x00 outputs programmable 1-16MHz clock; as input fires buffer exchange.
// - Input codes 0x01-0x07 fire mask clear/set, rx on, cca sample, ack strobes.
// - Input codes 0x08-0x0F fire tx, flushes, pop, calibrate, radio and oscillator off.
// - Output codes 0x01-0x0C drive the first twelve exception flags in order.
// - Output codes 0x0D-0x18 drive the remaining twelve exception flags in order.
// - Code 0x21 is high when any flag in collection A is active.
// - Code 0x22 is high when any flag in collection B is active.
// - Code 0x23 is high when any active flag lies outside collection A.
// - Code 0x24 is high when any active flag lies outside collection B.
// - Code 0x25 ORs rx underrun, rx overrun, rx frame cut, rx move timeout.
// - Code 0x26 ORs bad address, misuse, bad operand and serial port error.
// - Code 0x27 is high with any byte buffered, low during overflow.
// - Code 0x28 high above threshold, on complete frame, or during overflow.
// - Function register MSB selects input or output direction.
// - Low seven function bits pick the strobe fired by an input edge.
// - Polarity bit picks rising or falling edge; reset selects rising on every pin.
`timescale 1ns/1ps
`include "gfs_consts.svh"

module gfs_top
	import gfs_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [`GFS_NUM_PINS-1:0] pin_in,
	output logic [`GFS_NUM_PINS-1:0] pin_out,
	output logic [`GFS_NUM_PINS-1:0] pin_oe,
	input wire logic [`GFS_NUM_EXC-1:0] exc_flags,
	input wire logic [7:0] rx_byte_count,
	input wire logic rx_frame_buffered,
	input wire logic rx_overflow,
	output logic irq,
	output logic strobe_buffer_exchange,
	output logic strobe_rx_mask_clear,
	output logic strobe_rx_mask_set,
	output logic strobe_receive_on,
	output logic strobe_sample_channel_clear,
	output logic strobe_send_acknowledge,
	output logic strobe_ack_with_pending,
	output logic strobe_ack_without_pending,
	output logic strobe_transmit_on,
	output logic strobe_transmit_if_clear,
	output logic strobe_flush_receive_buffer,
	output logic strobe_flush_transmit_buffer,
	output logic strobe_pop_receive_byte,
	output logic strobe_synth_calibrate,
	output logic strobe_radio_off,
	output logic strobe_oscillator_off
);

	////////////////////////////////////////////////////////////////////////////
	// Exception flag positions, bit n is output code n+1

	localparam int EXC_RX_UNDER = 5;
	localparam int EXC_RX_OVER = 6;
	localparam int EXC_MEM_ADDR = 16;
	localparam int EXC_MISUSE = 17;
	localparam int EXC_OPERAND = 18;
	localparam int EXC_SPI = 19;
	localparam int EXC_RX_CUT = 21;
	localparam int EXC_RX_MOVE_TO = 22;

	gfs_state_s q;
	gfs_state_s next_q;

	logic [`GFS_NUM_PINS-1:0] edge_seen;
	logic chan_a;
	logic chan_b;
	logic nchan_a;
	logic nchan_b;
	logic rx_err;
	logic gen_err;
	logic fifo_level;
	logic fifop_level;

	////////////////////////////////////////////////////////////////////////////
	// Edge detectors, one per pin

	genvar gp;
	generate
		for (gp = 0; gp < `GFS_NUM_PINS; gp++) begin : g_edge
			gfs_edge u_edge (
				.core_clk(core_clk),
				.rst(rst),
				.pin_async(pin_in[gp]),
				.rising_sel(q.polarity[gp]),
				.edge_pulse(edge_seen[gp])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Channel and buffer indications

	always_comb begin
		chan_a = |(exc_flags & q.mask_a);
		chan_b = |(exc_flags & q.mask_b);
		nchan_a = |(exc_flags & ~q.mask_a);
		nchan_b = |(exc_flags & ~q.mask_b);
		rx_err = exc_flags[EXC_RX_UNDER] | exc_flags[EXC_RX_OVER]
			| exc_flags[EXC_RX_CUT] | exc_flags[EXC_RX_MOVE_TO];
		gen_err = exc_flags[EXC_MEM_ADDR] | exc_flags[EXC_MISUSE]
			| exc_flags[EXC_OPERAND] | exc_flags[EXC_SPI];
		fifo_level = (rx_byte_count != 8'h00) & ~rx_overflow;
		// Own level indication, independent of the threshold exception flag
		fifop_level = (rx_byte_count > q.rx_thresh) | rx_frame_buffered
			| rx_overflow;
	end

	////////////////////////////////////////////////////////////////////////////
	// Output signal selection for one function code

	function automatic logic out_select(
		input logic [`GFS_CODE_MSB:0] code,
		input logic clk_level,
		input logic [`GFS_NUM_EXC-1:0] flags,
		input logic [7:0] chans
	);
		logic sel;
		logic [6:0] idx;
		sel = 1'b0;
		idx = 7'h00;
		if (code == `GFS_CODE_CLOCK) begin
			sel = clk_level;
		end else if (code >= `GFS_CODE_EXC_FIRST && code <= `GFS_CODE_EXC_LAST) begin
			idx = code - `GFS_CODE_EXC_FIRST;
			sel = flags[idx[4:0]];
		end else begin
			case (code)
				`GFS_CODE_CHAN_A: sel = chans[0];
				`GFS_CODE_CHAN_B: sel = chans[1];
				`GFS_CODE_NCHAN_A: sel = chans[2];
				`GFS_CODE_NCHAN_B: sel = chans[3];
				`GFS_CODE_RX_ERR: sel = chans[4];
				`GFS_CODE_GEN_ERR: sel = chans[5];
				`GFS_CODE_FIFO: sel = chans[6];
				`GFS_CODE_FIFOP: sel = chans[7];
				// Reserved and unsupported codes stay low
				default: sel = 1'b0;
			endcase
		end
		return sel;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic [6:0] nco_sum;
		logic [7:0] chans;
		logic [`GFS_NUM_PINS-1:0] fired;
		logic [4:0] freq_w;
		logic [2:0] pin_idx;
		logic sel;
		nco_sum = 7'h00;
		chans = 8'h00;
		fired = '0;
		freq_w = 5'h00;
		pin_idx = 3'h0;
		sel = 1'b0;
		next_q = q;

		// Clock generator: accumulate twice the frequency per cycle, toggle on
		// each wrap of the core rate. Exact on average; except at 20MHz/n the edges
		// jitter by one core period, a trade made to reach 16MHz from 40MHz.
		nco_sum = {1'b0, q.nco_acc} + {1'b0, q.clk_freq, 1'b0};
		if (nco_sum >= `GFS_CORE_MHZ) begin
			next_q.nco_acc = 6'(nco_sum - `GFS_CORE_MHZ);
			next_q.clk_level = ~q.clk_level;
		end else begin
			next_q.nco_acc = nco_sum[5:0];
		end

		chans = {fifop_level, fifo_level, gen_err, rx_err, nchan_b, nchan_a, chan_b, chan_a};

		// Pins: direction, outputs, and strobes from input edges
		next_q.strobes = '0;
		for (int p = 0; p < `GFS_NUM_PINS; p++) begin
			if (q.func[p][`GFS_DIR_BIT]) begin
				next_q.pin_oe[p] = 1'b0;
				next_q.pin_out[p] = 1'b0;
				if (edge_seen[p] && q.func[p][`GFS_CODE_MSB:0] <= `GFS_CODE_STROBE_LAST) begin
					// Pins sharing a strobe in one cycle merge into one pulse
					next_q.strobes[q.func[p][3:0]] = 1'b1;
					fired[p] = 1'b1;
				end
			end else begin
				next_q.pin_oe[p] = 1'b1;
				sel = out_select(q.func[p][`GFS_CODE_MSB:0], q.clk_level, exc_flags, chans);
				next_q.pin_out[p] = sel ^ ~q.polarity[p];
			end
		end

		// Register port
		next_q.rd_data = 32'h0000_0000;
		if (reg_wr) begin
			if (reg_addr >= `GFS_ADDR_FUNC0 && reg_addr <= `GFS_ADDR_FUNC5
				&& reg_addr[1:0] == 2'h0) begin
				pin_idx = reg_addr[4:2];
				next_q.func[pin_idx] = reg_wdata[7:0];
			end else begin
				case (reg_addr)
					`GFS_ADDR_POLARITY: next_q.polarity = reg_wdata[`GFS_NUM_PINS-1:0];
					`GFS_ADDR_MASK_A: next_q.mask_a = reg_wdata[`GFS_NUM_EXC-1:0];
					`GFS_ADDR_MASK_B: next_q.mask_b = reg_wdata[`GFS_NUM_EXC-1:0];
					`GFS_ADDR_CLK_FREQ: begin
						freq_w = reg_wdata[4:0];
						if (reg_wdata[31:5] != 27'h0 || freq_w > `GFS_CLK_MAX_MHZ) begin
							freq_w = `GFS_CLK_MAX_MHZ;
						end else if (freq_w < `GFS_CLK_MIN_MHZ) begin
							freq_w = `GFS_CLK_MIN_MHZ;
						end
						next_q.clk_freq = freq_w;
					end
					`GFS_ADDR_RX_THRESH: next_q.rx_thresh = reg_wdata[7:0];
					`GFS_ADDR_INT_CLEAR: begin
						next_q.int_status = q.int_status & ~reg_wdata[`GFS_NUM_PINS-1:0];
					end
					`GFS_ADDR_INT_ENABLE: next_q.int_enable = reg_wdata[`GFS_NUM_PINS-1:0];
					default: begin
					end
				endcase
			end
		end
		if (reg_rd) begin
			if (reg_addr >= `GFS_ADDR_FUNC0 && reg_addr <= `GFS_ADDR_FUNC5
				&& reg_addr[1:0] == 2'h0) begin
				pin_idx = reg_addr[4:2];
				next_q.rd_data = {24'h00_0000, q.func[pin_idx]};
			end else begin
				case (reg_addr)
					`GFS_ADDR_POLARITY: next_q.rd_data = {26'h0, q.polarity};
					`GFS_ADDR_MASK_A: next_q.rd_data = {8'h00, q.mask_a};
					`GFS_ADDR_MASK_B: next_q.rd_data = {8'h00, q.mask_b};
					`GFS_ADDR_CLK_FREQ: next_q.rd_data = {27'h0, q.clk_freq};
					`GFS_ADDR_RX_THRESH: next_q.rd_data = {24'h00_0000, q.rx_thresh};
					`GFS_ADDR_INT_STATUS: next_q.rd_data = {26'h0, q.int_status};
					`GFS_ADDR_INT_ENABLE: next_q.rd_data = {26'h0, q.int_enable};
					default: next_q.rd_data = 32'h0000_0000;
				endcase
			end
		end

		// A strobe in the clearing cycle survives the clear
		next_q.int_status = next_q.int_status | fired;
		next_q.irq = |(next_q.int_status & next_q.int_enable);
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge core_clk) begin
		if (rst) begin
			q <= '0;
			q.func[0] <= `GFS_RST_FUNC0;
			q.func[1] <= `GFS_RST_FUNC1;
			q.func[2] <= `GFS_RST_FUNC2;
			q.func[3] <= `GFS_RST_FUNC3;
			q.func[4] <= `GFS_RST_FUNC4;
			q.func[5] <= `GFS_RST_FUNC5;
			q.polarity <= `GFS_RST_POLARITY;
			q.clk_freq <= `GFS_RST_CLK_FREQ;
			q.rx_thresh <= `GFS_RST_RX_THRESH;
		end else begin
			q <= next_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign reg_rdata = q.rd_data;
	assign pin_out = q.pin_out;
	assign pin_oe = q.pin_oe;
	assign irq = q.irq;
	assign strobe_buffer_exchange = q.strobes[0];
	assign strobe_rx_mask_clear = q.strobes[1];
	assign strobe_rx_mask_set = q.strobes[2];
	assign strobe_receive_on = q.strobes[3];
	assign strobe_sample_channel_clear = q.strobes[4];
	assign strobe_send_acknowledge = q.strobes[5];
	assign strobe_ack_with_pending = q.strobes[6];
	assign strobe_ack_without_pending = q.strobes[7];
	assign strobe_transmit_on = q.strobes[8];
	assign strobe_transmit_if_clear = q.strobes[9];
	assign strobe_flush_receive_buffer = q.strobes[10];
	assign strobe_flush_transmit_buffer = q.strobes[11];
	assign strobe_pop_receive_byte = q.strobes[12];
	assign strobe_synth_calibrate = q.strobes[13];
	assign strobe_radio_off = q.strobes[14];
	assign strobe_oscillator_off = q.strobes[15];

endmodule

// file: pkg/gfs_consts.svh
/*
 * Constants for the pin function selector: register addresses, field
 * positions, reset values, function codes and clock generator figures.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef GFS_CONSTS_SVH
`define GFS_CONSTS_SVH

`define GFS_NUM_PINS 6
`define GFS_NUM_EXC 24
`define GFS_NUM_STROBES 16

`define GFS_ADDR_FUNC0 8'h00
`define GFS_ADDR_FUNC5 8'h14
`define GFS_ADDR_POLARITY 8'h18
`define GFS_ADDR_MASK_A 8'h1c
`define GFS_ADDR_MASK_B 8'h20
`define GFS_ADDR_CLK_FREQ 8'h24
`define GFS_ADDR_RX_THRESH 8'h28
`define GFS_ADDR_INT_STATUS 8'h2c
`define GFS_ADDR_INT_CLEAR 8'h30
`define GFS_ADDR_INT_ENABLE 8'h34

`define GFS_DIR_BIT 7
`define GFS_CODE_MSB 6

`define GFS_RST_FUNC0 8'h00
`define GFS_RST_FUNC1 8'h27
`define GFS_RST_FUNC2 8'h28
`define GFS_RST_FUNC3 8'h29
`define GFS_RST_FUNC4 8'h2a
`define GFS_RST_FUNC5 8'h90
`define GFS_RST_POLARITY 6'h3f
`define GFS_RST_CLK_FREQ 5'h01
`define GFS_RST_RX_THRESH 8'h40

`define GFS_CODE_CLOCK 7'h00
`define GFS_CODE_EXC_FIRST 7'h01
`define GFS_CODE_EXC_LAST 7'h18
`define GFS_CODE_CHAN_A 7'h21
`define GFS_CODE_CHAN_B 7'h22
`define GFS_CODE_NCHAN_A 7'h23
`define GFS_CODE_NCHAN_B 7'h24
`define GFS_CODE_RX_ERR 7'h25
`define GFS_CODE_GEN_ERR 7'h26
`define GFS_CODE_FIFO 7'h27
`define GFS_CODE_FIFOP 7'h28
`define GFS_CODE_STROBE_LAST 7'h0f

`define GFS_CORE_MHZ 7'd40
`define GFS_CLK_MIN_MHZ 5'd1
`define GFS_CLK_MAX_MHZ 5'd16

`endif

// file: pkg/gfs_pkg.sv
/*
 * Types for the pin function selector: the state records of the top
 * module and of the per-pin edge detector.
 * Assumes the constants header is on the include path.
 */
`include "gfs_consts.svh"

package gfs_pkg;

	typedef logic [7:0] gfs_func_t;

	typedef struct packed {
		gfs_func_t [`GFS_NUM_PINS-1:0] func;
		logic [`GFS_NUM_PINS-1:0] polarity;
		logic [`GFS_NUM_EXC-1:0] mask_a;
		logic [`GFS_NUM_EXC-1:0] mask_b;
		logic [4:0] clk_freq;
		logic [7:0] rx_thresh;
		logic [`GFS_NUM_PINS-1:0] int_status;
		logic [`GFS_NUM_PINS-1:0] int_enable;
		logic [31:0] rd_data;
		logic [`GFS_NUM_PINS-1:0] pin_out;
		logic [`GFS_NUM_PINS-1:0] pin_oe;
		logic [`GFS_NUM_STROBES-1:0] strobes;
		logic irq;
		logic [5:0] nco_acc;
		logic clk_level;
	} gfs_state_s;

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
		logic [1:0] warm;
		logic pulse;
	} gfs_edge_s;

endpackage

// file: design/gfs_edge.sv
/*
 * Per-pin edge detector: two-flop synchroniser, then a chosen-edge detector
 * giving a one-cycle pulse.
 * Assumes the pin is asynchronous to core_clk and holds each level
 * for at least two core_clk periods.
 */
`timescale 1ns/1ps

module gfs_edge
	import gfs_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic pin_async,
	input wire logic rising_sel,
	output logic edge_pulse
);

	gfs_edge_s q;
	gfs_edge_s next_q;

	always_comb begin
		next_q = q;
		next_q.sync1 = pin_async;
		next_q.sync2 = q.sync1;
		next_q.prev = q.sync2;
		// Hold off until prev carries a real pin level, or reset could fake an edge
		if (q.warm != 2'h3) begin
			next_q.warm = q.warm + 2'h1;
		end
		next_q.pulse = 1'b0;
		if (q.warm == 2'h3) begin
			if (rising_sel) begin
				next_q.pulse = q.sync2 & ~q.prev;
			end else begin
				next_q.pulse = ~q.sync2 & q.prev;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign edge_pulse = q.pulse;

endmodule

// file: tb/gfs_checker.sv
/* Port-level assertions for the pin function selector.
 * Assumes binding to gfs_top; a shadow of the function and polarity
 * registers is rebuilt here from the writes seen on the register port. */
`timescale 1ns/1ps
`include "gfs_consts.svh"

module gfs_checker
	import gfs_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [5:0] pin_in,
	input wire logic [5:0] pin_out,
	input wire logic [5:0] pin_oe,
	input wire logic [23:0] exc_flags,
	input wire logic irq,
	input wire logic strobe_buffer_exchange,
	input wire logic strobe_rx_mask_clear,
	input wire logic strobe_rx_mask_set,
	input wire logic strobe_receive_on,
	input wire logic strobe_sample_channel_clear,
	input wire logic strobe_send_acknowledge,
	input wire logic strobe_ack_with_pending,
	input wire logic strobe_ack_without_pending,
	input wire logic strobe_transmit_on,
	input wire logic strobe_transmit_if_clear,
	input wire logic strobe_flush_receive_buffer,
	input wire logic strobe_flush_transmit_buffer,
	input wire logic strobe_pop_receive_byte,
	input wire logic strobe_synth_calibrate,
	input wire logic strobe_radio_off,
	input wire logic strobe_oscillator_off
);
	logic [15:0] sv;
	gfs_func_t [5:0] fn;
	logic [5:0] pol;
	logic [5:0] dir;
	logic [1:0] q;
	logic [6:0] c3;
	logic [6:0] c5;
	assign sv = {strobe_oscillator_off, strobe_radio_off, strobe_synth_calibrate,
		strobe_pop_receive_byte, strobe_flush_transmit_buffer, strobe_flush_receive_buffer,
		strobe_transmit_if_clear, strobe_transmit_on, strobe_ack_without_pending,
		strobe_ack_with_pending, strobe_send_acknowledge, strobe_sample_channel_clear,
		strobe_receive_on, strobe_rx_mask_set, strobe_rx_mask_clear, strobe_buffer_exchange};
	assign dir = {fn[5][7], fn[4][7], fn[3][7], fn[2][7], fn[1][7], fn[0][7]};
	assign c3 = fn[3][6:0];
	assign c5 = fn[5][6:0];
	////////////////////////////////////////////////////////////////////////////////
	// Quiet count: pin outputs lag a configuration write by two cycles
	always_ff @(posedge core_clk) begin
		if (rst) begin
			fn <= {8'h90, 8'h2a, 8'h29, 8'h28, 8'h27, 8'h00};
			pol <= 6'h3f;
			q <= 2'h0;
		end else begin
			q <= reg_wr ? 2'h0 : (q == 2'h3 ? q : q + 2'h1);
			if (reg_wr && reg_addr <= `GFS_ADDR_FUNC5 && reg_addr[1:0] == 2'h0) begin
				fn[reg_addr[4:2]] <= reg_wdata[7:0];
			end
			if (reg_wr && reg_addr == `GFS_ADDR_POLARITY) begin
				pol <= reg_wdata[5:0];
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	property p_reset_quiet;
		disable iff (1'b0) rst |=> (sv == 16'h0 && irq == 1'b0 && reg_rdata == 32'h0 && pin_oe == 6'h0);
	endproperty
	property p_strobe_pulse;
		sv != 16'h0 |=> (sv & $past(sv)) == 16'h0;
	endproperty
	property p_rdata_idle;
		!$past(reg_rd) |-> reg_rdata == 32'h0;
	endproperty
	property p_in_low;
		(pin_out & ~pin_oe) == 6'h0;
	endproperty
	property p_dir;
		q >= 2'h2 |-> pin_oe == ~dir;
	endproperty
	property p_exc;
		q >= 2'h2 && !fn[3][7] && c3 >= 7'h01 && c3 <= 7'h18
		|-> pin_out[3] == ($past(exc_flags[c3 - 7'h01]) ^ ~pol[3]);
	endproperty
	property p_reserved;
		q >= 2'h2 && !fn[3][7] && c3 >= 7'h19 && c3 <= 7'h20 |-> pin_out[3] == ~pol[3];
	endproperty
	property p_fire;
		q >= 2'h2 && fn[5][7] && c5 <= 7'h0f && pol[5] && $rose(pin_in[5]) |-> ##[2:5] sv[c5[3:0]];
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not quiet after reset");
	a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe longer than one cycle");
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");
	a_in_low: assert property (p_in_low) else $error("input pin has drive value");
	a_dir: assert property (p_dir) else $error("output enable disagrees with direction bit");
	a_exc: assert property (p_exc) else $error("exception flag not on pin");
	a_reserved: assert property (p_reserved) else $error("reserved code not low");
	a_fire: assert property (p_fire) else $error("edge fired no strobe");
	c_fire: cover property (sv != 16'h0);
	c_irq: cover property ($rose(irq));
	c_exc: cover property (!fn[3][7] && c3 == 7'h18 && pin_out[3]);
endmodule

// file: tb/gfs_host_model.sv
/* Host pin model: drives the pins that the selector leaves as inputs.
 * Assumes the bench asks for levels through set_level. */
`timescale 1ns/1ps

module gfs_host_model #(
	parameter int HOLD_CYC = 3
) (
	input wire logic core_clk,
	input wire logic [5:0] pin_oe,
	input wire logic [5:0] pin_out,
	output logic [5:0] pin_in
);
	logic [5:0] drv = 6'h00;
	// Device drive wins wherever it enables its output
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv);
	// Level held for several clocks so the synchroniser cannot miss it
	task automatic set_level(input int p, input logic v);
		@(posedge core_clk);
		drv[p] <= v;
		repeat (HOLD_CYC) @(posedge core_clk);
	endtask
endmodule

// file: tb/tb_top.sv
/* Top bench: register tasks, pin output and strobe scenarios, verdict.
 * Assumes gfs_top with its checker bound and the host pin model. */
`timescale 1ns/1ps
`include "gfs_consts.svh"

module tb_top;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [5:0] pin_in, pin_out, pin_oe;
	logic [23:0] exc_flags = 24'h0;
	logic [7:0] rx_byte_count = 8'h00;
	logic rx_frame_buffered = 1'b0;
	logic rx_overflow = 1'b0;
	logic irq;
	logic strobe_buffer_exchange, strobe_rx_mask_clear, strobe_rx_mask_set, strobe_receive_on;
	logic strobe_sample_channel_clear, strobe_send_acknowledge, strobe_ack_with_pending;
	logic strobe_ack_without_pending, strobe_transmit_on, strobe_transmit_if_clear;
	logic strobe_flush_receive_buffer, strobe_flush_transmit_buffer, strobe_pop_receive_byte;
	logic strobe_synth_calibrate, strobe_radio_off, strobe_oscillator_off;
	logic [15:0] sv;
	logic [7:0] rv [6] = '{8'h00, 8'h27, 8'h28, 8'h29, 8'h2a, 8'h90};
	int err_count = 0;
	int total_checks = 0;
	int n;
	assign sv = {strobe_oscillator_off, strobe_radio_off, strobe_synth_calibrate,
		strobe_pop_receive_byte, strobe_flush_transmit_buffer, strobe_flush_receive_buffer,
		strobe_transmit_if_clear, strobe_transmit_on, strobe_ack_without_pending,
		strobe_ack_with_pending, strobe_send_acknowledge, strobe_sample_channel_clear,
		strobe_receive_on, strobe_rx_mask_set, strobe_rx_mask_clear, strobe_buffer_exchange};
	gfs_top gfs_top_inst (.*);
	gfs_host_model gfs_host_model_inst (.*);
	initial begin
		forever #12.5 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(nm, reg_rdata, exp);
	endtask
	// Pin 3 as output with code c, given flag and buffer inputs
	task automatic oc(input logic [6:0] c, input logic [23:0] f, input logic [7:0] cnt,
		input logic [1:0] fo, input logic e);
		@(posedge core_clk);
		exc_flags <= f;
		rx_byte_count <= cnt;
		{rx_frame_buffered, rx_overflow} <= fo;
		wr(8'h0c, {25'h0, c});
		repeat (3) @(posedge core_clk);
		#1;
		chk("pin3", pin_out[3], e);
	endtask
	// Pin 5 as input with code c; one edge to level lvl; e is the expected strobe set
	task automatic fire(input logic [6:0] c, input logic pe, input logic lvl, input logic [15:0] e);
		logic [15:0] seen;
		int k;
		seen = 16'h0;
		k = 0;
		wr(`GFS_ADDR_FUNC5, {24'h0, 1'b1, c});
		wr(`GFS_ADDR_POLARITY, {26'h0, pe, 5'h1f});
		repeat (3) @(posedge core_clk);
		gfs_host_model_inst.set_level(5, lvl);
		repeat (6) begin
			@(posedge core_clk);
			#1;
			seen = seen | sv;
			k = k + int'(sv != 16'h0);
		end
		chk("strobe", {16'h0, seen}, {16'h0, e});
		chk("pulses", k, int'(e != 16'h0));
	endtask
	// Rising edges of the clock pin over 200 cycles
	task automatic clk_rises(input int exp);
		int k;
		logic prev;
		k = 0;
		// Skip the launch edge and the cycle that still shows the old rate
		repeat (2) @(posedge core_clk);
		#1;
		prev = pin_out[0];
		repeat (200) begin
			@(posedge core_clk);
			#1;
			k = k + int'(pin_out[0] && !prev);
			prev = pin_out[0];
		end
		chk("clock rises", k, exp);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge core_clk);
		err_count++;
		report_and_stop();
	end
	initial begin
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		repeat (8) @(posedge core_clk);
		#1;
		chk("oe", pin_oe, 6'h1f);
		for (n = 0; n < 6; n++) rd(8'(4 * n), rv[n], "func");
		rd(`GFS_ADDR_POLARITY, 32'h3f, "polarity");
		rd(`GFS_ADDR_RX_THRESH, 32'h40, "thresh");
		rd(8'h3c, 32'h0, "unmapped");
		rd(8'h01, 32'h0, "unaligned");
		clk_rises(5);
		wr(`GFS_ADDR_CLK_FREQ, 32'h10);
		clk_rises(80);
		for (n = 1; n <= 24; n++) begin
			oc(7'(n), 24'h1 << (n - 1), 8'h00, 2'h0, 1'b1);
			oc(7'(n), ~(24'h1 << (n - 1)), 8'h00, 2'h0, 1'b0);
		end
		for (n = 8'h19; n <= 8'h20; n++) oc(7'(n), 24'hffffff, 8'h00, 2'h0, 1'b0);
		wr(`GFS_ADDR_MASK_A, 32'h0f);
		wr(`GFS_ADDR_MASK_B, 32'hf0);
		oc(7'h21, 24'h000004, 8'h00, 2'h0, 1'b1);
		oc(7'h21, 24'h000010, 8'h00, 2'h0, 1'b0);
		oc(7'h22, 24'h000010, 8'h00, 2'h0, 1'b1);
		oc(7'h22, 24'h000004, 8'h00, 2'h0, 1'b0);
		oc(7'h23, 24'h000004, 8'h00, 2'h0, 1'b0);
		oc(7'h23, 24'h000100, 8'h00, 2'h0, 1'b1);
		oc(7'h24, 24'h000010, 8'h00, 2'h0, 1'b0);
		oc(7'h24, 24'h000004, 8'h00, 2'h0, 1'b1);
		oc(7'h25, 24'h400000, 8'h00, 2'h0, 1'b1);
		oc(7'h25, 24'h100000, 8'h00, 2'h0, 1'b0);
		oc(7'h26, 24'h080000, 8'h00, 2'h0, 1'b1);
		oc(7'h26, 24'h008000, 8'h00, 2'h0, 1'b0);
		oc(7'h27, 24'h0, 8'h01, 2'h0, 1'b1);
		oc(7'h27, 24'h0, 8'h01, 2'h1, 1'b0);
		oc(7'h27, 24'h0, 8'h00, 2'h0, 1'b0);
		oc(7'h28, 24'h0, 8'h41, 2'h0, 1'b1);
		oc(7'h28, 24'h0, 8'h40, 2'h0, 1'b0);
		oc(7'h28, 24'h0, 8'h00, 2'h2, 1'b1);
		oc(7'h28, 24'h0, 8'h00, 2'h1, 1'b1);
		for (n = 0; n < 16; n++) begin
			fire(7'(n), 1'b1, 1'b1, 16'h1 << n);
			fire(7'(n), 1'b1, 1'b0, 16'h0);
		end
		fire(7'h03, 1'b0, 1'b1, 16'h0);
		fire(7'h03, 1'b0, 1'b0, 16'h0008);
		fire(7'h43, 1'b1, 1'b1, 16'h0);
		fire(7'h43, 1'b1, 1'b0, 16'h0);
		wr(`GFS_ADDR_INT_STATUS, 32'h0);
		rd(`GFS_ADDR_INT_STATUS, 32'h20, "status");
		chk("irq masked", irq, 1'b0);
		wr(`GFS_ADDR_INT_ENABLE, 32'h20);
		repeat (2) @(posedge core_clk);
		#1;
		chk("irq", irq, 1'b1);
		wr(`GFS_ADDR_INT_CLEAR, 32'h20);
		repeat (2) @(posedge core_clk);
		#1;
		chk("irq cleared", irq, 1'b0);
		rd(`GFS_ADDR_INT_STATUS, 32'h0, "status cleared");
		report_and_stop();
	end
endmodule

bind gfs_top gfs_checker gfs_checker_inst (.*);
